// >>> asp_serial_port.sv
// Serial port of a sigma-delta converter: read/write framing, clocking modes, ready flag
`timescale 1ns/1ps
// How it works
// - Strap high: device makes the serial clock and drives it during transfers.
// - Strap low: serial clock is an input supplied by the host.
// - Read with select high gives the output word, low gives control.
// - Ready flag goes low when a fresh result lands in the output register.
// - Ready flag returns high after the last bit, 16 or 24, is sent.
// - Unread results keep overwriting the output register; latest word is read.
// - A result arriving mid output read is dropped silently.
// - Read strobe with ready high moves no output register data.
// - Control reads neither need nor change the ready flag.
// - Self-clocked read: strobe fall starts clock and shows the top bit.
// - Later bits shift on falling clock edges, most significant first.
// - Self-clocked output read: next fall after last bit raises ready and releases pins.
// - Writes ignore and keep the ready flag; always 24 bits.
// - Select picks control or calibration target during writes, held stable.
// - Self-clocked write: strobe fall starts clock; bits sampled on rising edges.
// - Self-clocked write: clock released after the fall following the last bit.
// - External output read: last fall raises ready and releases data.
// - External read: lifting the strobe mid-word releases data; ready stays low until done.
// - Write with select low loads control, high loads calibration.
// - External write: bits captured while the host clock is high.
module asp_serial_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_mode,
    input wire logic register_select,
    input wire logic read_frame_strobe_n,
    input wire logic write_frame_strobe_n,
    input wire logic sclk_in,
    input wire logic sdata_in,
    input wire logic result_valid,
    input wire asp_pkg::asp_word_t result_word,
    output logic result_ready,
    output logic sclk_out,
    output logic sclk_oe,
    output logic sdata_out,
    output logic sdata_oe,
    output logic result_ready_n,
    output asp_pkg::asp_word_t ctrl_word,
    output logic [23:0] cal_word
);
    // Two-flop synchronisers for all pins from outside the clock domain
    logic [1:0] s_mode, s_sel, s_rfs, s_tfs, s_sck, s_sdi;
    logic mode_q, sel_q, rfs_q, tfs_q, sck_q, sdi_q;
    logic rfs_d, tfs_d, sck_d;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_mode <= 2'h0;
            s_sel <= 2'h0;
            s_rfs <= 2'h3;
            s_tfs <= 2'h3;
            s_sck <= 2'h0;
            s_sdi <= 2'h0;
        end else begin
            s_mode <= {s_mode[0], clock_mode};
            s_sel <= {s_sel[0], register_select};
            s_rfs <= {s_rfs[0], read_frame_strobe_n};
            s_tfs <= {s_tfs[0], write_frame_strobe_n};
            s_sck <= {s_sck[0], sclk_in};
            s_sdi <= {s_sdi[0], sdata_in};
        end
    end
    assign mode_q = s_mode[1];
    assign sel_q = s_sel[1];
    assign rfs_q = s_rfs[1];
    assign tfs_q = s_tfs[1];
    assign sck_q = s_sck[1];
    assign sdi_q = s_sdi[1];

    // Delayed copies for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rfs_d <= 1'b1;
            tfs_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            rfs_d <= rfs_q;
            tfs_d <= tfs_q;
            sck_d <= sck_q;
        end
    end

    // Two-entry result buffer: producer stalls only when both slots hold words
    asp_pkg::asp_word_t buf_mem [2];
    logic [1:0] buf_cnt;
    logic buf_wp, buf_rp;
    logic buf_take;
    logic buf_valid;
    assign buf_valid = (buf_cnt != 2'h0);

    // Buffer fill after one cycle of pushes and pops; shared by count and ready
    function automatic logic [1:0] next_count(input logic [1:0] cnt, input logic inc,
                                              input logic dec);
        return cnt + 2'(inc) - 2'(dec);
    endfunction : next_count

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_cnt <= 2'h0;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            result_ready <= 1'b1;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (result_valid && result_ready) begin
                buf_mem[buf_wp] <= result_word;
                buf_wp <= ~buf_wp;
            end
            if (buf_take) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= next_count(buf_cnt, result_valid && result_ready, buf_take);
            result_ready <= next_count(buf_cnt, result_valid && result_ready, buf_take) < 2'h2;
        end
    end

    // Transfer state
    asp_pkg::asp_state_t state;
    asp_pkg::asp_word_t out_reg;
    logic [23:0] shreg;
    logic [4:0] bits_left;
    logic is_out_read;
    logic wr_sel;
    logic [7:0] div_cnt;
    logic gen_sck;
    logic gen_rise, gen_fall;
    logic rise, fall;
    logic read_busy;

    // Terminal count of the half-period divider, shared by both edge strobes
    // and the divider itself so that they can never disagree
    function automatic logic half_done(input logic [7:0] cnt);
        return cnt == (asp_pkg::HALF_CYC - 8'h01);
    endfunction : half_done

    // Internal clock divider, running only while a self-clocked transfer is active
    assign gen_rise = (state != asp_pkg::ST_IDLE) && mode_q && !gen_sck
                      && half_done(div_cnt);
    assign gen_fall = (state != asp_pkg::ST_IDLE) && mode_q && gen_sck
                      && half_done(div_cnt);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
            gen_sck <= 1'b0;
        end else if (state == asp_pkg::ST_IDLE || !mode_q) begin
            div_cnt <= 8'h00;
            gen_sck <= 1'b0;
        end else if (half_done(div_cnt)) begin
            div_cnt <= 8'h00;
            gen_sck <= ~gen_sck;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Edges come from the generator or from the sampled host clock
    assign rise = mode_q ? gen_rise : (sck_q && !sck_d);
    assign fall = mode_q ? gen_fall : (!sck_q && sck_d);
    assign read_busy = (state == asp_pkg::ST_READ) && is_out_read;

    // Output word: newest result overwrites unless an output read is under way
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= '0;
        end else if (buf_valid && !read_busy) begin
            out_reg <= buf_mem[buf_rp];
        end
    end
    // Results arriving mid output read are drained and dropped
    assign buf_take = buf_valid;

    // Ready flag: set wins over clear when both land in one cycle
    logic ready_clear;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ready_n <= 1'b1;
        end else if (buf_valid && !read_busy) begin
            result_ready_n <= 1'b0;
        end else if (ready_clear) begin
            result_ready_n <= 1'b1;
        end
    end

    // Main transfer sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= asp_pkg::ST_IDLE;
            shreg <= 24'h000000;
            bits_left <= 5'h00;
            is_out_read <= 1'b0;
            wr_sel <= 1'b0;
            ctrl_word <= '{data: asp_pkg::CTRL_RESET, short_word: 1'b0};
            cal_word <= asp_pkg::CAL_RESET;
            ready_clear <= 1'b0;
        end else begin
            ready_clear <= 1'b0;
            case (state)
                asp_pkg::ST_IDLE: begin
                    if (!rfs_q && rfs_d) begin
                        if (sel_q) begin
                            if (!result_ready_n) begin
                                state <= asp_pkg::ST_READ;
                                is_out_read <= 1'b1;
                                shreg <= out_reg.short_word ? {out_reg.data[15:0], 8'h00}
                                                            : out_reg.data;
                                bits_left <= out_reg.short_word ? asp_pkg::CNT_SHORT
                                                                : asp_pkg::CNT_LONG;
                            end
                        end else begin
                            state <= asp_pkg::ST_READ;
                            is_out_read <= 1'b0;
                            shreg <= ctrl_word.data;
                            bits_left <= asp_pkg::CNT_LONG;
                        end
                    end else if (!tfs_q && tfs_d) begin
                        state <= asp_pkg::ST_WRITE;
                        wr_sel <= sel_q;
                        bits_left <= asp_pkg::CNT_LONG;
                        shreg <= 24'h000000;
                    end
                end
                asp_pkg::ST_READ: begin
                    // With the host clock, strobe high pauses the shift; progress is kept
                    if (fall && (!rfs_q || mode_q)) begin
                        if (bits_left == 5'h01) begin
                            state <= asp_pkg::ST_IDLE;
                            ready_clear <= is_out_read;
                            bits_left <= 5'h00;
                        end else begin
                            shreg <= {shreg[22:0], 1'b0};
                            bits_left <= bits_left - 5'h01;
                        end
                    end
                end
                asp_pkg::ST_WRITE: begin
                    if (rise && (!tfs_q || mode_q)) begin
                        shreg <= {shreg[22:0], sdi_q};
                        bits_left <= bits_left - 5'h01;
                        if (bits_left == 5'h01) begin
                            state <= asp_pkg::ST_DONE;
                        end
                    end
                end
                asp_pkg::ST_DONE: begin
                    if (wr_sel) begin
                        cal_word <= shreg;
                    end else begin
                        ctrl_word.data <= shreg;
                    end
                    state <= mode_q ? asp_pkg::ST_DONE : asp_pkg::ST_IDLE;
                    if (!mode_q || fall) begin
                        state <= asp_pkg::ST_IDLE;
                    end
                end
                default: state <= asp_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin drivers, all registered; idle leaves both lines to the pull resistor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            sdata_out <= 1'b0;
            sdata_oe <= 1'b0;
        end else begin
            sclk_out <= gen_sck;
            // Held one cycle past the end so the final falling edge reaches the pin
            sclk_oe <= mode_q && ((state != asp_pkg::ST_IDLE) || sclk_out);
            sdata_out <= shreg[23];
            sdata_oe <= (state == asp_pkg::ST_READ) && (mode_q || !rfs_q);
        end
    end

    // A low ready flag stays low across register reads
    AST_REG_READ_KEEPS_READY:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_READ) && !is_out_read && !result_ready_n |=> !result_ready_n)
    else $error("register read disturbed ready");

    AST_IDLE_RELEASE:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_IDLE) [*2] |=> !sdata_oe && !sclk_oe)
    else $error("pins driven while idle");

    AST_NO_READ_WHEN_NOT_READY:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_IDLE && !rfs_q && rfs_d && sel_q && result_ready_n)
        |=> state == asp_pkg::ST_IDLE)
    else $error("output read started without ready");

    AST_READY_CLEAR_AFTER_READ:
    assert property (@(posedge clk) disable iff (!rst_n)
        ready_clear && !(buf_valid && !read_busy) |=> result_ready_n)
    else $error("ready not raised after last bit");

    AST_WRITE_NO_READY_CHANGE:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_WRITE) && !buf_valid |=> $stable(result_ready_n))
    else $error("write changed ready");

    AST_SELF_CLOCK_DRIVEN:
    assert property (@(posedge clk) disable iff (!rst_n)
        mode_q && (state == asp_pkg::ST_READ) && $past(state == asp_pkg::ST_READ)
        |-> sclk_oe)
    else $error("self clock not driven");

    AST_EXT_NO_CLOCK_DRIVE:
    assert property (@(posedge clk) disable iff (!rst_n)
        !mode_q && $past(!mode_q) |-> !sclk_oe)
    else $error("clock driven in external mode");

    AST_SHORT_WORD_COUNT:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_IDLE) ##1 (state == asp_pkg::ST_READ)
        |-> bits_left == asp_pkg::CNT_SHORT || bits_left == asp_pkg::CNT_LONG)
    else $error("bad read length");

    // Data line stays driven through a self-clocked read
    AST_SELF_READ_DATA_DRIVEN:
    assert property (@(posedge clk) disable iff (!rst_n)
        mode_q && (state == asp_pkg::ST_READ) && $past(state == asp_pkg::ST_READ)
        |-> sdata_oe)
    else $error("read data not driven");

    // A paused external read leaves the data line to the pull resistor
    AST_PAUSE_RELEASES_DATA:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_READ) && !mode_q && rfs_q |=> !sdata_oe)
    else $error("data driven while read paused");

    // A result arriving mid-read never touches the word being read
    AST_OUT_HELD_DURING_READ:
    assert property (@(posedge clk) disable iff (!rst_n)
        read_busy |=> $stable(out_reg))
    else $error("output word changed during read");

    // A buffered result outside an output read lowers the ready flag
    AST_RESULT_SETS_READY:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state == asp_pkg::ST_IDLE) && buf_valid |=> !result_ready_n)
    else $error("fresh result not flagged");
endmodule : asp_serial_port

// >>> asp_pkg.sv
// Package of constants and carrier types for the converter serial port
package asp_pkg;
    localparam int WORD_BITS = 24;
    localparam int SHORT_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_LONG = 5'h18;
    localparam logic [4:0] CNT_SHORT = 5'h10;
    // Half period of the generated serial clock in ns, and in system clock cycles rounded up
    localparam int SCLK_HALF_NS = 250;
    localparam int CLK_NS = 10;
    localparam logic [7:0] HALF_CYC = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [23:0] CTRL_RESET = 24'h000000;
    localparam logic [23:0] CAL_RESET = 24'h000000;

    typedef struct packed {
        logic [23:0] data;
        logic short_word;
    } asp_word_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WRITE = 4'h4,
        ST_DONE = 4'h8
    } asp_state_t;
endpackage : asp_pkg

// >>> asp_host.sv
// Host model: frames transfers, makes the external clock, samples serial data
`timescale 1ns/1ps
module asp_host (
    input wire logic clk,
    input wire logic clock_mode,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic sdata_out,
    input wire logic sdata_oe,
    output logic register_select,
    output logic read_frame_strobe_n,
    output logic write_frame_strobe_n,
    output logic sclk_in,
    output logic sdata_in
);
    logic host_clk;
    logic line;
    // Pull-up holds the released clock line high; host clock rests low
    assign line = clock_mode ? (sclk_oe ? sclk_out : 1'b1) : host_clk;
    assign sclk_in = line;
    initial begin
        host_clk = 1'b0;
        register_select = 1'b0;
        read_frame_strobe_n = 1'b1;
        write_frame_strobe_n = 1'b1;
        sdata_in = 1'b0;
    end
    // One frame; split pauses an external-clock read before that bit, only while the clock is low
    task automatic xfer(input bit wr, input bit sel, input int n, input int split,
                        input logic [23:0] wd, output logic [23:0] rd, output int got,
                        output logic pz);
        int w;
        logic p;
        rd = '0;
        got = 0;
        pz = 1'b0;
        w = 0;
        @(posedge clk);
        register_select <= sel;
        if (wr) write_frame_strobe_n <= 1'b0;
        else read_frame_strobe_n <= 1'b0;
        if (wr) sdata_in <= wd[n-1];
        if (clock_mode) begin
            p = line;
            while (got < n && w < 100) begin
                @(negedge clk);
                w++;
                if (sclk_oe && !p && line) begin
                    rd = {rd[22:0], sdata_oe ? sdata_out : 1'bx};
                    got++;
                    w = 0;
                end
                if (wr && sclk_oe && p && !line && got < n) sdata_in <= wd[n-1-got];
                p = line;
            end
            w = 0;
            while (sclk_oe && w < 100) begin
                @(negedge clk);
                w++;
            end
        end else begin
            // Host clock edges sit between system clock edges to avoid races
            #201.25;
            for (int i = 0; i < n; i++) begin
                if (i == split) begin
                    // Strobe rises a few cycles into the low phase
                    repeat (3) @(posedge clk);
                    read_frame_strobe_n <= 1'b1;
                    #201.25 pz = sdata_oe;
                    @(posedge clk) read_frame_strobe_n <= 1'b0;
                    #201.25;
                end
                if (wr) sdata_in = wd[n-1-i];
                #62.5 host_clk = 1'b1;
                // Sample in the high phase; the bit settles a few cycles after the fall
                if (!wr) rd = {rd[22:0], sdata_oe ? sdata_out : 1'bx};
                got++;
                #62.5 host_clk = 1'b0;
            end
            #200;
        end
        @(posedge clk);
        read_frame_strobe_n <= 1'b1;
        write_frame_strobe_n <= 1'b1;
        sdata_in <= ~sdata_in;
        repeat (4) @(posedge clk);
    endtask : xfer
endmodule : asp_host

// >>> tb.sv
// Self-checking bench of the converter serial port
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clock_mode = 1'b1;
    logic result_valid = 1'b0;
    asp_pkg::asp_word_t result_word = '0;
    logic register_select, read_frame_strobe_n, write_frame_strobe_n, sclk_in, sdata_in;
    logic result_ready, sclk_out, sclk_oe, sdata_out, sdata_oe, result_ready_n;
    asp_pkg::asp_word_t ctrl_word;
    logic [23:0] cal_word, rd;
    logic pz;
    int got;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    asp_serial_port uut (.clk(clk), .rst_n(rst_n), .clock_mode(clock_mode),
        .register_select(register_select), .read_frame_strobe_n(read_frame_strobe_n),
        .write_frame_strobe_n(write_frame_strobe_n), .sclk_in(sclk_in), .sdata_in(sdata_in),
        .result_valid(result_valid), .result_word(result_word), .result_ready(result_ready),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
        .result_ready_n(result_ready_n), .ctrl_word(ctrl_word), .cal_word(cal_word));
    asp_host host (.clk(clk), .clock_mode(clock_mode), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .sdata_out(sdata_out), .sdata_oe(sdata_oe), .register_select(register_select),
        .read_frame_strobe_n(read_frame_strobe_n), .write_frame_strobe_n(write_frame_strobe_n),
        .sclk_in(sclk_in), .sdata_in(sdata_in));
    always #5 clk = ~clk;
    // Hang guard: the whole run needs well under 10000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Offers one result; ready is read at the falling edge so it is settled
    task automatic push(input logic [23:0] d, input logic s);
        int w;
        w = 0;
        @(posedge clk);
        result_valid <= 1'b1;
        result_word <= '{data: d, short_word: s};
        @(negedge clk);
        while (result_ready !== 1'b1 && w < 50) begin
            @(negedge clk);
            w++;
        end
        if (w >= 50) begin
            errors++;
            $display("[ERR] %0t: result offer not accepted", $time);
        end
        @(posedge clk);
        result_valid <= 1'b0;
    endtask : push
    task automatic mode(input logic m);
        @(posedge clk) clock_mode <= m;
        repeat (10) @(posedge clk);
    endtask : mode
    task automatic t_reset();
        chk(sclk_oe, 1'b0);
        chk(sdata_oe, 1'b0);
        chk(result_ready_n, 1'b1);
        chk(result_ready, 1'b1);
        chk(ctrl_word.data, asp_pkg::CTRL_RESET);
    endtask : t_reset
    task automatic t_write_ctrl_self();
        host.xfer(1'b1, 1'b0, 24, 99, 24'hA5C3F1, rd, got, pz);
        chk(ctrl_word.data, 24'hA5C3F1);
        chk(cal_word, asp_pkg::CAL_RESET);
        chk(result_ready_n, 1'b1);
        chk(sclk_oe, 1'b0);
    endtask : t_write_ctrl_self
    task automatic t_write_cal_ext();
        mode(1'b0);
        host.xfer(1'b1, 1'b1, 24, 99, 24'h3C5A96, rd, got, pz);
        chk(cal_word, 24'h3C5A96);
        chk(ctrl_word.data, 24'hA5C3F1);
        mode(1'b1);
    endtask : t_write_cal_ext
    task automatic t_out_self();
        host.xfer(1'b0, 1'b1, 24, 99, 24'h0, rd, got, pz);
        chk(got, 0);
        push(24'h123456, 1'b0);
        push(24'h654321, 1'b0);
        repeat (4) @(posedge clk);
        chk(result_ready_n, 1'b0);
        host.xfer(1'b0, 1'b1, 24, 99, 24'h0, rd, got, pz);
        chk(rd, 24'h654321);
        chk(result_ready_n, 1'b1);
        chk({sclk_oe, sdata_oe}, 2'h0);
    endtask : t_out_self
    // A result lands mid control read: ready falls, the read is unaffected
    task automatic t_ctrl_read_self();
        fork
            host.xfer(1'b0, 1'b0, 24, 99, 24'h0, rd, got, pz);
            begin
                repeat (300) @(posedge clk);
                push(24'h0ACE55, 1'b0);
            end
        join
        chk(rd, 24'hA5C3F1);
        chk(result_ready_n, 1'b0);
    endtask : t_ctrl_read_self
    // Short word, split read, and a result dropped while the read runs
    task automatic t_short_ext();
        mode(1'b0);
        push(24'h00BEEF, 1'b1);
        fork
            host.xfer(1'b0, 1'b1, 16, 8, 24'h0, rd, got, pz);
            begin
                repeat (150) @(posedge clk);
                push(24'h777777, 1'b0);
            end
        join
        chk(rd[15:0], 16'hBEEF);
        chk(pz, 1'b0);
        chk(result_ready_n, 1'b1);
        chk(sdata_oe, 1'b0);
    endtask : t_short_ext
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_write_ctrl_self();
        t_write_cal_ext();
        t_out_self();
        t_ctrl_read_self();
        t_short_ext();
        end_of_test();
    end
endmodule : tb
